// ==== core/mbs_defines.svh ====
// Constants of the table-access server: offsets, fields, codes, timing.
// Assumes a 50 MHz system clock and a byte-wide receive and transmit stream.
// Function
// - Own node address 1..247, act on own or broadcast
// - Server replies only, never transmits unprompted
// - Reply: address, function echo, data, checksum
// - Broadcast requests reach every server
// - Four tables: coils, inputs, two registers
// - Supports codes 01 02 03 04 05 06 15 16
// - Code 03 holding, code 04 input registers
// - Register writes only holding; 06 single, 10h many
// - Bit codes: 01, 05, 0Fh, 02
// - True sets coil, false clears; one per coil
// - Every access: start address and item count
// - 32-bit value spans two consecutive registers
// - Word order within value is selectable
// - Byte order reversible for 32-bit values
// - 16-bit values zero or sign extended
// - Unsigned 32-bit above limit shows negative
// - Client and server engines share data; only the server engine is built here
// - Inactive until enabled by configuration
// - Silence of 1.5 characters ends frame
// - Serial server uses binary framing with check
// - Sleep after 40 s idle; first packet wakes
// - Unsupported function returns illegal-function exception
`ifndef MBS_DEFINES_SVH
`define MBS_DEFINES_SVH

// ==========================================
// Register offsets
`define MBS_OFF_CTRL      8'h00
`define MBS_OFF_NODE      8'h04
`define MBS_OFF_STATUS    8'h08
`define MBS_OFF_COILS     8'h0c
`define MBS_OFF_DISC      8'h10
`define MBS_OFF_CONV_CFG  8'h14
`define MBS_OFF_CONV_VAL  8'h18
`define MBS_OFF_HOLD      8'h40
`define MBS_OFF_INP       8'h60

// ==========================================
// Fields and reset values
`define MBS_CTRL_EN       0
`define MBS_CTRL_AON      1
`define MBS_STAT_BUSY     0
`define MBS_STAT_SLEEP    1
`define MBS_NODE_RST      8'h01
`define MBS_NODE_MAX      8'hf7
`define MBS_BCAST         8'h00

// ==========================================
// Function and exception codes
`define MBS_FC_RD_COILS   8'h01
`define MBS_FC_RD_DISC    8'h02
`define MBS_FC_RD_HOLD    8'h03
`define MBS_FC_RD_INP     8'h04
`define MBS_FC_WR_COIL    8'h05
`define MBS_FC_WR_HOLD    8'h06
`define MBS_FC_WR_COILS   8'h0f
`define MBS_FC_WR_HOLDS   8'h10
`define MBS_EXC_FLAG      8'h80
`define MBS_EXC_FUNC      8'h01
`define MBS_EXC_ADDR      8'h02
`define MBS_EXC_VALUE     8'h03
`define MBS_COIL_ON       16'hff00
`define MBS_COIL_OFF      16'h0000
`define MBS_CRC_INIT      16'hffff
`define MBS_CRC_POLY      16'ha001

// ==========================================
// Sizes
`define MBS_N_COILS       16
`define MBS_N_REGS        8
`define MBS_RXBUF         32
`define MBS_MIN_FRAME     6'h08

// ==========================================
// Timing
`define MBS_CLK_NS        20
`define MBS_CLK_HZ        50000000
`define MBS_GAP_NS        859375
`define MBS_SLEEP_S       40

`endif

// ==== core/mbs_pkg.sv ====
// Types of the table-access server.
// Holds its own encodings; takes nothing from mbs_defines.svh.
package mbs_pkg;

	typedef enum logic [1:0] {
		ST_RECV  = 2'b00,
		ST_PARSE = 2'b01,
		ST_WRITE = 2'b10,
		ST_SEND  = 2'b11
	} mbs_state_e;

	typedef enum logic [2:0] {
		DT_U16 = 3'b000,
		DT_S16 = 3'b001,
		DT_S32 = 3'b010,
		DT_U32 = 3'b011,
		DT_F32 = 3'b100
	} mbs_dtype_e;

	typedef struct packed {
		logic       always_on;
		logic       enable;
		logic [7:0] node;
	} mbs_ctrl_s;

	typedef struct packed {
		logic       byte_swap;
		logic       word_swap;
		mbs_dtype_e dtype;
		logic       tbl_input;
		logic [2:0] pair;
	} mbs_conv_s;

	typedef logic [15:0] mbs_word_t;

endpackage

// ==== core/mbs_server.sv ====
// Request interpreter and data tables of a binary-framed table-access server.
// Assumes a byte stream from a serial receiver and a byte sink with ready.
`timescale 1ns/1ps
`include "mbs_defines.svh"
module mbs_server
	import mbs_pkg::*;
#(
	parameter int unsigned GAP_CYCLES   = (`MBS_GAP_NS + `MBS_CLK_NS - 1) / `MBS_CLK_NS,
	parameter int unsigned SLEEP_CYCLES = `MBS_SLEEP_S * `MBS_CLK_HZ
) (
	input  wire logic        ref_clk_i,
	input  wire logic        resetn_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	input  wire logic        rx_valid_i,
	input  wire logic [7:0]  rx_data_i,
	output logic             tx_valid_o,
	output logic      [7:0]  tx_data_o,
	input  wire logic        tx_ready_i,
	output logic      [15:0] coils_o
);

	// ==========================================
	// State
	mbs_state_e  state;
	mbs_ctrl_s   ctrl;
	mbs_conv_s   conv;
	logic [15:0] coils;
	logic [15:0] disc;
	mbs_word_t   hold [`MBS_N_REGS];
	mbs_word_t   inp  [`MBS_N_REGS];
	logic [7:0]  rx_buf [`MBS_RXBUF];
	logic [5:0]  rx_cnt;
	logic        rx_ovf;
	logic [15:0] rx_crc;
	logic [31:0] gap_cnt;
	logic [30:0] idle_cnt;
	logic        asleep;
	logic [7:0]  fc_q;
	logic [7:0]  exc_q;
	logic [3:0]  start_q;
	logic [4:0]  items_q;
	logic        reply_q;
	logic [4:0]  k_cnt;
	logic [5:0]  tx_len;
	logic [5:0]  tx_idx;
	logic [15:0] tx_crc;

	logic        frame_end;
	logic [7:0]  p_fc;
	logic [15:0] p_start;
	logic [15:0] p_qty;
	logic [16:0] p_end;
	logic [5:0]  p_bsum;
	logic [7:0]  p_bc;
	logic [7:0]  p_exc;
	logic [4:0]  p_items;
	logic [5:0]  p_len;
	logic        p_drop;
	logic        p_write;
	logic        p_bcast;
	logic        tx_load;
	logic [7:0]  tx_byte;
	logic [15:0] bits_resp;
	logic [15:0] bits_mask;
	logic [5:0]  tx_off;
	logic [2:0]  rd_idx;
	mbs_word_t   rd_word;
	logic [3:0]  cw_idx;
	logic [2:0]  hw_idx;
	mbs_word_t   hw_val;
	logic        hw_en;
	mbs_word_t   cv_w0;
	mbs_word_t   cv_w1;
	logic [31:0] cv_raw;
	logic [15:0] cv_half;
	logic [31:0] conv_val;

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ `MBS_CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	// ==========================================
	// Receive and frame delimiting
	assign frame_end = (state == ST_RECV) && (rx_cnt != 6'h00) && (gap_cnt == GAP_CYCLES - 1);

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			rx_cnt  <= 6'h00;
			rx_ovf  <= 1'b0;
			rx_crc  <= `MBS_CRC_INIT;
			gap_cnt <= 32'h0000_0000;
		end else if (state == ST_RECV && ctrl.enable) begin
			if (rx_valid_i) begin
				if (rx_cnt < 6'(`MBS_RXBUF)) begin
					rx_cnt <= rx_cnt + 6'h01;
				end else begin
					rx_ovf <= 1'b1;
				end
				rx_crc  <= crc_step(rx_crc, rx_data_i);
				gap_cnt <= 32'h0000_0000;
			end else if (rx_cnt != 6'h00) begin
				gap_cnt <= gap_cnt + 32'h0000_0001;
			end
		end else if (state != ST_WRITE && state != ST_SEND) begin
			rx_cnt  <= 6'h00;
			rx_ovf  <= 1'b0;
			rx_crc  <= `MBS_CRC_INIT;
			gap_cnt <= 32'h0000_0000;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (state == ST_RECV && ctrl.enable && rx_valid_i && rx_cnt < 6'(`MBS_RXBUF)) begin
			rx_buf[rx_cnt[4:0]] <= rx_data_i;
		end
	end

	// ==========================================
	// Request decode
	always_comb begin
		p_fc    = rx_buf[1];
		p_start = {rx_buf[2], rx_buf[3]};
		p_qty   = {rx_buf[4], rx_buf[5]};
		p_end   = {1'b0, p_start} + {1'b0, p_qty};
		p_bsum  = {1'b0, p_qty[4:0]} + 6'h07;
		p_bc    = {5'h00, p_bsum[5:3]};
		p_bcast = (rx_buf[0] == `MBS_BCAST);
		p_drop  = rx_ovf || (rx_cnt < `MBS_MIN_FRAME) || (rx_crc != 16'h0000)
			|| (!p_bcast && rx_buf[0] != ctrl.node) || asleep;
		p_exc   = 8'h00;
		p_items = 5'h01;
		p_len   = 6'h06;
		p_write = 1'b0;
		case (p_fc)
			`MBS_FC_RD_COILS, `MBS_FC_RD_DISC: begin
				if (p_qty == 16'h0000 || p_qty > 16'(`MBS_N_COILS)) begin
					p_exc = `MBS_EXC_VALUE;
				end else if (p_end > 17'(`MBS_N_COILS)) begin
					p_exc = `MBS_EXC_ADDR;
				end
				p_items = p_qty[4:0];
				p_len   = 6'h03 + p_bc[5:0];
			end
			`MBS_FC_RD_HOLD, `MBS_FC_RD_INP: begin
				if (p_qty == 16'h0000 || p_qty > 16'(`MBS_N_REGS)) begin
					p_exc = `MBS_EXC_VALUE;
				end else if (p_end > 17'(`MBS_N_REGS)) begin
					p_exc = `MBS_EXC_ADDR;
				end
				p_items = p_qty[4:0];
				p_len   = 6'h03 + {p_qty[4:0], 1'b0};
			end
			`MBS_FC_WR_COIL: begin
				p_write = 1'b1;
				if (p_start >= 16'(`MBS_N_COILS)) begin
					p_exc = `MBS_EXC_ADDR;
				end else if (p_qty != `MBS_COIL_ON && p_qty != `MBS_COIL_OFF) begin
					p_exc = `MBS_EXC_VALUE;
				end
			end
			`MBS_FC_WR_HOLD: begin
				p_write = 1'b1;
				if (p_start >= 16'(`MBS_N_REGS)) begin
					p_exc = `MBS_EXC_ADDR;
				end
			end
			`MBS_FC_WR_COILS: begin
				p_write = 1'b1;
				p_items = p_qty[4:0];
				if (p_qty == 16'h0000 || p_qty > 16'(`MBS_N_COILS) || rx_buf[6] != p_bc
					|| rx_cnt != 6'h09 + p_bc[5:0]) begin
					p_exc = `MBS_EXC_VALUE;
				end else if (p_end > 17'(`MBS_N_COILS)) begin
					p_exc = `MBS_EXC_ADDR;
				end
			end
			`MBS_FC_WR_HOLDS: begin
				p_write = 1'b1;
				p_items = p_qty[4:0];
				if (p_qty == 16'h0000 || p_qty > 16'(`MBS_N_REGS)
					|| rx_buf[6] != {2'b00, p_qty[4:0], 1'b0}
					|| rx_cnt != 6'h09 + {p_qty[4:0], 1'b0}) begin
					p_exc = `MBS_EXC_VALUE;
				end else if (p_end > 17'(`MBS_N_REGS)) begin
					p_exc = `MBS_EXC_ADDR;
				end
			end
			default: p_exc = `MBS_EXC_FUNC;
		endcase
		if (p_exc != 8'h00) begin
			p_len = 6'h03;
		end
	end

	// ==========================================
	// Sequencer
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			state   <= ST_RECV;
			fc_q    <= 8'h00;
			exc_q   <= 8'h00;
			start_q <= 4'h0;
			items_q <= 5'h01;
			reply_q <= 1'b0;
			k_cnt   <= 5'h00;
			tx_len  <= 6'h00;
		end else begin
			case (state)
				ST_RECV: begin
					if (frame_end && ctrl.enable) begin
						state <= ST_PARSE;
					end
				end
				ST_PARSE: begin
					fc_q    <= p_fc;
					exc_q   <= p_exc;
					start_q <= p_start[3:0];
					items_q <= p_items;
					reply_q <= !p_bcast;
					tx_len  <= p_len;
					k_cnt   <= 5'h00;
					if (p_drop) begin
						state <= ST_RECV;
					end else if (p_exc == 8'h00 && p_write) begin
						state <= ST_WRITE;
					end else if (!p_bcast) begin
						state <= ST_SEND;
					end else begin
						state <= ST_RECV;
					end
				end
				ST_WRITE: begin
					k_cnt <= k_cnt + 5'h01;
					if (k_cnt == items_q - 5'h01) begin
						state <= reply_q ? ST_SEND : ST_RECV;
					end
				end
				ST_SEND: begin
					if (tx_idx == tx_len + 6'h02 && (!tx_valid_o || tx_ready_i)) begin
						state <= ST_RECV;
					end
				end
				default: state <= ST_RECV;
			endcase
		end
	end

	// ==========================================
	// Sleep after idle
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			idle_cnt <= 31'h0000_0000;
			asleep   <= 1'b0;
		end else begin
			if (rx_valid_i || ctrl.always_on || !ctrl.enable) begin
				idle_cnt <= 31'h0000_0000;
			end else if (idle_cnt != 31'(SLEEP_CYCLES - 1)) begin
				idle_cnt <= idle_cnt + 31'h0000_0001;
			end
			if (ctrl.always_on) begin
				asleep <= 1'b0;
			end else if (idle_cnt == 31'(SLEEP_CYCLES - 1)) begin
				asleep <= 1'b1;
			end else if (state == ST_PARSE) begin
				asleep <= 1'b0;
			end
		end
	end

	// ==========================================
	// Table writes from requests and from the register port
	assign cw_idx = start_q + k_cnt[3:0];
	assign hw_idx = start_q[2:0] + k_cnt[2:0];
	assign hw_en  = (state == ST_WRITE) && (fc_q == `MBS_FC_WR_HOLD || fc_q == `MBS_FC_WR_HOLDS);
	assign hw_val = (fc_q == `MBS_FC_WR_HOLD) ? {rx_buf[4], rx_buf[5]}
		: {rx_buf[5'(5'h07 + {k_cnt[3:0], 1'b0})], rx_buf[5'(5'h08 + {k_cnt[3:0], 1'b0})]};

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			coils <= 16'h0000;
		end else if (state == ST_WRITE && fc_q == `MBS_FC_WR_COIL) begin
			coils[start_q] <= ({rx_buf[4], rx_buf[5]} == `MBS_COIL_ON);
		end else if (state == ST_WRITE && fc_q == `MBS_FC_WR_COILS) begin
			coils[cw_idx] <= rx_buf[5'(5'h07 + {3'b000, k_cnt[4:3]})][k_cnt[2:0]];
		end else if (wr_i && addr_i == `MBS_OFF_COILS) begin
			coils <= wdata_i[15:0];
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			disc <= 16'h0000;
		end else if (wr_i && addr_i == `MBS_OFF_DISC) begin
			disc <= wdata_i[15:0];
		end
	end

	assign coils_o = coils;

	for (genvar g = 0; g < `MBS_N_REGS; g++) begin : g_regs
		always_ff @(posedge ref_clk_i) begin
			if (!resetn_i) begin
				hold[g] <= 16'h0000;
			end else if (hw_en && hw_idx == 3'(g)) begin
				hold[g] <= hw_val;
			end else if (wr_i && addr_i == 8'(`MBS_OFF_HOLD + 4 * g)) begin
				hold[g] <= wdata_i[15:0];
			end
		end
		always_ff @(posedge ref_clk_i) begin
			if (!resetn_i) begin
				inp[g] <= 16'h0000;
			end else if (wr_i && addr_i == 8'(`MBS_OFF_INP + 4 * g)) begin
				inp[g] <= wdata_i[15:0];
			end
		end
	end

	// ==========================================
	// Reply bytes
	always_comb begin
		tx_off    = tx_idx - 6'h03;
		bits_mask = 16'((17'h0_0001 << items_q) - 17'h0_0001);
		bits_resp = (((fc_q == `MBS_FC_RD_COILS) ? coils : disc) >> start_q) & bits_mask;
		rd_idx    = start_q[2:0] + tx_off[3:1];
		rd_word   = (fc_q == `MBS_FC_RD_HOLD) ? hold[rd_idx] : inp[rd_idx];
		if (tx_idx == tx_len) begin
			tx_byte = tx_crc[7:0];
		end else if (tx_idx == tx_len + 6'h01) begin
			tx_byte = tx_crc[15:8];
		end else if (tx_idx == 6'h00) begin
			tx_byte = ctrl.node;
		end else if (tx_idx == 6'h01) begin
			tx_byte = (exc_q != 8'h00) ? (fc_q | `MBS_EXC_FLAG) : fc_q;
		end else if (tx_idx == 6'h02 && exc_q != 8'h00) begin
			tx_byte = exc_q;
		end else if (fc_q == `MBS_FC_RD_COILS || fc_q == `MBS_FC_RD_DISC) begin
			tx_byte = (tx_idx == 6'h02) ? {2'b00, tx_len - 6'h03}
				: (tx_off[0] ? bits_resp[15:8] : bits_resp[7:0]);
		end else if (fc_q == `MBS_FC_RD_HOLD || fc_q == `MBS_FC_RD_INP) begin
			tx_byte = (tx_idx == 6'h02) ? {2'b00, tx_len - 6'h03}
				: (tx_off[0] ? rd_word[7:0] : rd_word[15:8]);
		end else begin
			tx_byte = rx_buf[tx_idx[4:0]];
		end
	end

	assign tx_load = (state == ST_SEND) && (!tx_valid_o || tx_ready_i)
		&& (tx_idx <= tx_len + 6'h01);

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			tx_valid_o <= 1'b0;
			tx_data_o  <= 8'h00;
			tx_idx     <= 6'h00;
			tx_crc     <= `MBS_CRC_INIT;
		end else if (state == ST_PARSE) begin
			tx_idx <= 6'h00;
			tx_crc <= `MBS_CRC_INIT;
		end else if (tx_load) begin
			tx_valid_o <= 1'b1;
			tx_data_o  <= tx_byte;
			tx_idx     <= tx_idx + 6'h01;
			if (tx_idx < tx_len) begin
				tx_crc <= crc_step(tx_crc, tx_byte);
			end
		end else if (tx_ready_i) begin
			tx_valid_o <= 1'b0;
		end
	end

	// ==========================================
	// Value view of a register pair
	always_comb begin
		cv_w0   = conv.tbl_input ? inp[conv.pair] : hold[conv.pair];
		cv_w1   = conv.tbl_input ? inp[3'(conv.pair + 3'h1)] : hold[3'(conv.pair + 3'h1)];
		cv_raw  = conv.word_swap ? {cv_w1, cv_w0} : {cv_w0, cv_w1};
		cv_half = conv.byte_swap ? {cv_w0[7:0], cv_w0[15:8]} : cv_w0;
		if (conv.byte_swap) begin
			cv_raw = {cv_raw[7:0], cv_raw[15:8], cv_raw[23:16], cv_raw[31:24]};
		end
		case (conv.dtype)
			DT_U16:  conv_val = {16'h0000, cv_half};
			DT_S16:  conv_val = {{16{cv_half[15]}}, cv_half};
			default: conv_val = cv_raw;
		endcase
	end

	// ==========================================
	// Software register port
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			ctrl <= '{always_on: 1'b0, enable: 1'b0, node: `MBS_NODE_RST};
			conv <= '0;
		end else if (wr_i) begin
			if (addr_i == `MBS_OFF_CTRL) begin
				ctrl.enable    <= wdata_i[`MBS_CTRL_EN];
				ctrl.always_on <= wdata_i[`MBS_CTRL_AON];
			end else if (addr_i == `MBS_OFF_NODE) begin
				if (wdata_i[7:0] != 8'h00 && wdata_i[7:0] <= `MBS_NODE_MAX && wdata_i[31:8] == 24'h00_0000) begin
					ctrl.node <= wdata_i[7:0];
				end
			end else if (addr_i == `MBS_OFF_CONV_CFG) begin
				conv <= mbs_conv_s'(wdata_i[8:0]);
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			rdata_o <= 32'h0000_0000;
		end else if (!rd_i) begin
			rdata_o <= 32'h0000_0000;
		end else if (addr_i == `MBS_OFF_CTRL) begin
			rdata_o <= {30'h0000_0000, ctrl.always_on, ctrl.enable};
		end else if (addr_i == `MBS_OFF_NODE) begin
			rdata_o <= {24'h00_0000, ctrl.node};
		end else if (addr_i == `MBS_OFF_STATUS) begin
			rdata_o <= {28'h000_0000, state, asleep, (state != ST_RECV)};
		end else if (addr_i == `MBS_OFF_COILS) begin
			rdata_o <= {16'h0000, coils};
		end else if (addr_i == `MBS_OFF_DISC) begin
			rdata_o <= {16'h0000, disc};
		end else if (addr_i == `MBS_OFF_CONV_CFG) begin
			rdata_o <= {23'h00_0000, conv};
		end else if (addr_i == `MBS_OFF_CONV_VAL) begin
			rdata_o <= conv_val;
		end else if (addr_i >= `MBS_OFF_HOLD && addr_i < `MBS_OFF_INP && addr_i[1:0] == 2'b00) begin
			rdata_o <= {16'h0000, hold[addr_i[4:2]]};
		end else if (addr_i >= `MBS_OFF_INP && addr_i < 8'h80 && addr_i[1:0] == 2'b00) begin
			rdata_o <= {16'h0000, inp[addr_i[4:2]]};
		end else begin
			rdata_o <= 32'h0000_0000;
		end
	end

endmodule

// ==== bench/mbs_client.sv ====
// Client model on the far side of the server's byte stream.
// Assumes one request at a time and the design's checksum constants.
`timescale 1ns/1ps
`include "mbs_defines.svh"
module mbs_client
	import mbs_pkg::*;
#(
	parameter int TMO_CYCLES = 100
) (
	input  wire logic       ref_clk_i,
	input  wire logic       resetn_i,
	output logic            rx_valid_o,
	output logic      [7:0] rx_data_o,
	input  wire logic       tx_valid_i,
	input  wire logic [7:0] tx_data_i,
	output logic            tx_ready_o
);
	logic [7:0] rsp[$];
	logic       slow = 0;

	initial begin
		rx_valid_o = 0;
		rx_data_o = 0;
		tx_ready_o = 0;
	end

	// Reply sink, stalls every other cycle when slow
	always @(posedge ref_clk_i) begin
		tx_ready_o <= resetn_i && (slow ? !tx_ready_o : 1'b1);
		if (tx_valid_i && tx_ready_o)
			rsp.push_back(tx_data_i);
	end

	function automatic logic [15:0] crc(input logic [7:0] q[$]);
		crc = `MBS_CRC_INIT;
		foreach (q[i]) begin
			crc ^= {8'h00, q[i]};
			repeat (8) crc = crc[0] ? (crc >> 1) ^ `MBS_CRC_POLY : crc >> 1;
		end
	endfunction

	// Address, code, parameters, then checksum low byte first
	task automatic xfer(input logic [7:0] q[$], input bit bad);
		logic [15:0] c;
		c = crc(q) ^ {15'h0000, bad};
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
		rsp = {};
		foreach (q[i]) begin
			@(posedge ref_clk_i);
			rx_valid_o <= 1;
			rx_data_o <= q[i];
		end
		@(posedge ref_clk_i);
		rx_valid_o <= 0;
		rx_data_o <= ~q[q.size()-1];
		// Wait for the whole reply or give up
		for (int n = 0; n < TMO_CYCLES; n++) begin
			@(posedge ref_clk_i);
			if (rsp.size() > 0 && !tx_valid_i)
				break;
		end
	endtask
endmodule

// ==== bench/mbs_server_chk.sv ====
// Port checker of the table-access server.
// Assumes bind onto mbs_server and a frame gap of GAP_CYCLES.
`timescale 1ns/1ps
`include "mbs_defines.svh"
module mbs_chk
	import mbs_pkg::*;
#(
	parameter int unsigned GAP_CYCLES = 8
) (
	input wire logic        ref_clk_i,
	input wire logic        resetn_i,
	input wire logic [7:0]  addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic        rx_valid_i,
	input wire logic [7:0]  rx_data_i,
	input wire logic        tx_valid_o,
	input wire logic [7:0]  tx_data_o,
	input wire logic        tx_ready_i,
	input wire logic [15:0] coils_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);

	int unsigned quiet;
	int unsigned rxn;
	int unsigned txn;
	logic        pend;
	logic        en_m;
	logic [7:0]  first_m;
	logic [7:0]  fc_m;
	logic [7:0]  node_m;

	// ==========================================
	// Frame tracking
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			quiet <= GAP_CYCLES;
			rxn <= 0;
			pend <= 0;
			first_m <= 8'h00;
			fc_m <= 8'h00;
		end else begin
			if (tx_valid_o)
				pend <= 0;
			if (rx_valid_i) begin
				quiet <= 0;
				pend <= 1;
				rxn <= (quiet >= GAP_CYCLES) ? 1 : rxn + 1;
				if (quiet >= GAP_CYCLES)
					first_m <= rx_data_i;
				if (rxn == 1 && quiet < GAP_CYCLES)
					fc_m <= rx_data_i;
			end else if (quiet < GAP_CYCLES)
				quiet <= quiet + 1;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i || !tx_valid_o)
			txn <= 0;
		else if (tx_ready_i)
			txn <= txn + 1;
	end

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			node_m <= `MBS_NODE_RST;
			en_m <= 0;
		end else if (wr_i) begin
			if (addr_i == `MBS_OFF_CTRL)
				en_m <= wdata_i[`MBS_CTRL_EN];
			if (addr_i == `MBS_OFF_NODE && wdata_i[31:8] == 0 && wdata_i[7:0] != 0
				&& wdata_i[7:0] <= `MBS_NODE_MAX)
				node_m <= wdata_i[7:0];
		end
	end

	// ==========================================
	// Properties
	sequence s_exc;
		tx_valid_o && tx_ready_i && txn == 1 && tx_data_o[7];
	endsequence
	sequence s_code;
		tx_valid_o && txn == 2 && tx_data_o inside {8'h01, 8'h02, 8'h03};
	endsequence
	property p_coil;
		logic [15:0] d;
		(wr_i && addr_i == `MBS_OFF_COILS, d = wdata_i[15:0]) |=> coils_o == d;
	endproperty

	tx_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
		else $error("reply byte changed before taken");
	reply_pend_a: assert property ($rose(tx_valid_o) |-> pend)
		else $error("reply without request");
	reply_gap_a: assert property ($rose(tx_valid_o) |-> quiet >= GAP_CYCLES - 1)
		else $error("reply before frame gap");
	node_reply_a: assert property ($rose(tx_valid_o) |-> tx_data_o == node_m && first_m == node_m)
		else $error("reply address wrong");
	bcast_quiet_a: assert property ($rose(tx_valid_o) |-> first_m != `MBS_BCAST)
		else $error("broadcast answered");
	enable_gate_a: assert property ($rose(tx_valid_o) |-> en_m)
		else $error("reply while disabled");
	fc_echo_a: assert property (tx_valid_o && txn == 1 |-> tx_data_o[6:0] == fc_m[6:0])
		else $error("function code not echoed");
	exc_code_a: assert property (s_exc |-> ##[1:40] s_code)
		else $error("exception code missing");
	coil_write_a: assert property (p_coil)
		else $error("coil table write lost");
endmodule

bind mbs_server mbs_chk #(.GAP_CYCLES(GAP_CYCLES)) u_chk (
	.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
	.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_valid_i(rx_valid_i),
	.rx_data_i(rx_data_i), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
	.tx_ready_i(tx_ready_i), .coils_o(coils_o)
);

// ==== bench/test_modbus_server_table_access.sv ====
// Self-checking bench of the table-access server.
// Assumes mbs_client as far side and the checker bound to the design.
`timescale 1ns/1ps
`include "mbs_defines.svh"
module test_modbus_server_table_access
	import mbs_pkg::*;
;
	typedef struct {int rn; logic [87:0] rq; int pn; logic [71:0] rp;} mbs_row_s;

	logic        ref_clk_i = 0;
	logic        resetn_i = 0;
	logic        wr_i = 0;
	logic        rd_i = 0;
	logic [7:0]  addr_i = 0;
	logic [31:0] wdata_i = 0;
	logic [31:0] rdata_o;
	logic        rx_valid;
	logic        tx_valid;
	logic        tx_ready;
	logic [7:0]  rx_data;
	logic [7:0]  tx_data;
	logic [15:0] coils;
	int          mismatches = 0;
	int          checked = 0;
	mbs_row_s    rows[11];

	always #10 ref_clk_i = ~ref_clk_i;

	mbs_server #(.GAP_CYCLES(8), .SLEEP_CYCLES(200)) DUT (
		.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_valid_i(rx_valid),
		.rx_data_i(rx_data), .tx_valid_o(tx_valid), .tx_data_o(tx_data),
		.tx_ready_i(tx_ready), .coils_o(coils)
	);
	mbs_client #(.TMO_CYCLES(100)) u_client (
		.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .rx_valid_o(rx_valid),
		.rx_data_o(rx_data), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
		.tx_ready_o(tx_ready)
	);

	// ==========================================
	// Tasks
	task chk(string n, logic [31:0] s, logic [31:0] e);
		checked++;
		if (s !== e) begin
			mismatches++;
			$display("MISMATCH %s exp %h seen %h", n, e, s);
		end
	endtask
	task stop_test;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task wr(logic [7:0] a, logic [31:0] d);
		@(posedge ref_clk_i);
		wr_i <= 1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge ref_clk_i);
		wr_i <= 0;
	endtask
	task rd(logic [7:0] a, logic [31:0] e, string n);
		@(posedge ref_clk_i);
		rd_i <= 1;
		addr_i <= a;
		@(posedge ref_clk_i);
		rd_i <= 0;
		#1 chk(n, rdata_o, e);
	endtask
	task automatic xf(int n, logic [87:0] v, bit bad = 0);
		logic [7:0] q[$];
		for (int i = n - 1; i >= 0; i--)
			q.push_back(v[8*i +: 8]);
		u_client.xfer(q, bad);
	endtask
	task cmp(int pn, logic [71:0] v, string n);
		chk(n, u_client.rsp.size(), (pn > 0) ? pn + 2 : 0);
		for (int i = 0; i < pn && i < u_client.rsp.size(); i++)
			chk(n, u_client.rsp[i], v[8*(pn-1-i) +: 8]);
		if (pn > 0)
			chk(n, u_client.crc(u_client.rsp), 0);
		$display("test %s done", n);
	endtask

	initial begin
		repeat (20000) @(posedge ref_clk_i);
		mismatches++;
		stop_test;
	end

	// ==========================================
	// Sequence; starts are 0-based, offsets stripped
	initial begin
		rows = '{
			'{6, 88'h1103_0000_0002, 7, 72'h11_0304_1234_abcd},
			'{6, 88'h1104_0000_0001, 5, 72'h11_0402_5678},
			'{6, 88'h1102_0000_0003, 4, 72'h1102_0105},
			'{6, 88'h1105_0003_ff00, 6, 72'h1105_0003_ff00},
			'{6, 88'h1101_0000_0004, 4, 72'h1101_0109},
			'{6, 88'h1106_0002_0bee, 6, 72'h1106_0002_0bee},
			'{11, 88'h11_1000_0500_0204_0001_0002, 6, 72'h1110_0005_0002},
			'{9, 88'h11_0f00_0600_0a02_ff03, 6, 72'h110f_0006_000a},
			'{6, 88'h1107_0000_0001, 3, 72'h11_8701},
			'{6, 88'h1103_0007_0002, 3, 72'h11_8302},
			'{6, 88'h1103_0000_0000, 3, 72'h11_8303}
		};
		repeat (12) @(posedge ref_clk_i);
		resetn_i <= 1;
		rd(`MBS_OFF_NODE, 32'h0000_0001, "node_rst");
		chk("coils_rst", coils, 0);
		wr(`MBS_OFF_NODE, 32'h0000_0011);
		xf(6, 88'h1103_0000_0002);
		cmp(0, 0, "disabled");
		wr(`MBS_OFF_CTRL, 32'h0000_0003);
		wr(`MBS_OFF_HOLD, 32'h0000_1234);
		wr(`MBS_OFF_HOLD + 4, 32'h0000_abcd);
		wr(`MBS_OFF_INP, 32'h0000_5678);
		wr(`MBS_OFF_DISC, 32'h0000_0005);
		wr(`MBS_OFF_COILS, 32'h0000_0001);
		foreach (rows[i]) begin
			xf(rows[i].rn, rows[i].rq);
			cmp(rows[i].pn, rows[i].rp, $sformatf("row%0d", i));
		end
		chk("coils", coils, 16'hffc9);
		rd(`MBS_OFF_HOLD + 8, 32'h0000_0bee, "hold2");
		rd(`MBS_OFF_HOLD + 24, 32'h0000_0002, "hold6");
		wr(`MBS_OFF_CONV_CFG, 32'h0000_0001);
		rd(`MBS_OFF_CONV_VAL, 32'h0000_abcd, "u16");
		wr(`MBS_OFF_CONV_CFG, 32'h0000_0011);
		rd(`MBS_OFF_CONV_VAL, 32'hffff_abcd, "s16");
		wr(`MBS_OFF_CONV_CFG, 32'h0000_0030);
		rd(`MBS_OFF_CONV_VAL, 32'h1234_abcd, "u32");
		wr(`MBS_OFF_CONV_CFG, 32'h0000_00b0);
		rd(`MBS_OFF_CONV_VAL, 32'habcd_1234, "wswap");
		wr(`MBS_OFF_CONV_CFG, 32'h0000_0130);
		rd(`MBS_OFF_CONV_VAL, 32'hcdab_3412, "bswap");
		$display("test convert done");
		wr(`MBS_OFF_NODE, 32'h0000_00f8);
		wr(`MBS_OFF_NODE, 32'h0000_0000);
		rd(`MBS_OFF_NODE, 32'h0000_0011, "node_bad");
		xf(6, 88'h1203_0000_0001);
		cmp(0, 0, "other_node");
		xf(6, 88'h0006_0001_0042);
		cmp(0, 0, "bcast");
		rd(`MBS_OFF_HOLD + 4, 32'h0000_0042, "bcast_wr");
		xf(6, 88'h1106_0000_9999, 1);
		cmp(0, 0, "bad_crc");
		rd(`MBS_OFF_HOLD, 32'h0000_1234, "crc_kept");
		wr(`MBS_OFF_CTRL, 32'h0000_0001);
		repeat (210) @(posedge ref_clk_i);
		rd(`MBS_OFF_STATUS, 32'h0000_0002, "asleep");
		xf(rows[1].rn, rows[1].rq);
		cmp(0, 0, "wake");
		u_client.slow = 1;
		xf(rows[1].rn, rows[1].rq);
		cmp(rows[1].pn, rows[1].rp, "slow");
		u_client.slow = 0;
		stop_test;
	end
endmodule
